/* hw/i2cxm_baud.sv */
// Purpose: Baud rate generator, one tick per rollover
// Assumes: Reload held stable while counting
// Notes: Period is reload plus one cycles
`timescale 1ns/100ps

module i2cxm_baud (
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic enable_in,
	input wire logic [7:0] reload_in,
	output logic tick_out
);

	logic [7:0] count_r;
	logic [7:0] count_nxt;

	// ----------------------------------------
	// Down counter, reloads when idle or on rollover
	// ----------------------------------------
	always_comb begin
		tick_out = enable_in && (count_r == 8'h00);
		if (!enable_in || tick_out) begin
			count_nxt = reload_in;
		end else begin
			count_nxt = count_r - 8'h01;
		end
	end

	// Counter register
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			count_r <= 8'h00;
		end else begin
			count_r <= count_nxt;
		end
	end

endmodule // i2cxm_baud

/* hw/i2cxm_map.svh */
// Purpose: Timing constants for the two-wire serial port
// Assumes: 100 MHz system clock
// Notes: Definitions only
`ifndef I2CXM_MAP_SVH
`define I2CXM_MAP_SVH

// ----------------------------------------
// Clock and collision window timing
// ----------------------------------------
`define I2CXM_CLK_NS 10
`define I2CXM_TCY_NS 40
`define I2CXM_WRITE_COLLISION_FLAG_TCY 2
`define I2CXM_WRITE_COLLISION_FLAG_WIN_CYC ((`I2CXM_WRITE_COLLISION_FLAG_TCY * `I2CXM_TCY_NS + `I2CXM_CLK_NS - 1) / `I2CXM_CLK_NS)

// ----------------------------------------
// Byte framing
// ----------------------------------------
`define I2CXM_BITS_PER_BYTE 8
`define I2CXM_RW_BIT 0

`endif

/* hw/i2cxm_pkg.sv */
// Purpose: Types for the two-wire serial port
// Assumes: Nothing
// Notes: One-hot state codes
package i2cxm_pkg;

	// ----------------------------------------
	// Port state machine
	// ----------------------------------------
	typedef enum logic [6:0] {
		ST_IDLE   = 7'h01,
		ST_SADDR  = 7'h02,
		ST_SACK   = 7'h04,
		ST_SRX    = 7'h08,
		ST_STX    = 7'h10,
		ST_STXACK = 7'h20,
		ST_MTX    = 7'h40
	} i2cxm_state_t;

endpackage

/* hw/i2cxm_top.sv */
// Purpose: Two-wire port: slave receive/transmit and master transmit
// Assumes: Start condition for master mode made elsewhere; SCL low on entry
// Notes: Open-drain pins as input, output, output enable
`timescale 1ns/100ps
`include "i2cxm_map.svh"

module i2cxm_top (
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic scl_in,
	output logic scl_out,
	output logic scl_oe_out,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_out,
	input wire logic master_mode_in,
	input wire logic stretch_enable_in,
	input wire logic [6:0] own_address_in,
	input wire logic [7:0] baud_reload_in,
	input wire logic buf_wr_in,
	input wire logic [7:0] buf_wdata_in,
	input wire logic buf_rd_in,
	input wire logic clock_release_set_in,
	input wire logic int_clr_in,
	input wire logic write_collision_flag_clr_in,
	input wire logic ovf_clr_in,
	output logic [7:0] serial_data_buffer_out,
	output logic buffer_full_flag_out,
	output logic receive_overflow_flag_out,
	output logic write_collision_flag_out,
	output logic port_interrupt_flag_out,
	output logic read_write_out,
	output logic acknowledge_status_bit_out,
	output logic clock_release_bit_out
);

	localparam logic [3:0] WIN_CYC = 4'(`I2CXM_WRITE_COLLISION_FLAG_WIN_CYC);
	localparam logic [3:0] LAST_BIT = 4'(`I2CXM_BITS_PER_BYTE);

	// Seven-bit address compare against own address
	function automatic logic addr_match(input logic [7:0] byte_v, input logic [6:0] own_v);
		addr_match = (byte_v[7:1] == own_v);
	endfunction

	// ----------------------------------------
	// Pin synchronisers and edge detection
	// ----------------------------------------
	logic scl_s1_r, scl_s2_r, scl_d_r, sda_s1_r, sda_s2_r, sda_d_r;
	logic scl_rise, scl_fall, start_det, stop_det;

	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			scl_s1_r <= 1'b1;
			scl_s2_r <= 1'b1;
			scl_d_r <= 1'b1;
			sda_s1_r <= 1'b1;
			sda_s2_r <= 1'b1;
			sda_d_r <= 1'b1;
		end else begin
			scl_s1_r <= scl_in;
			scl_s2_r <= scl_s1_r;
			scl_d_r <= scl_s2_r;
			sda_s1_r <= sda_in;
			sda_s2_r <= sda_s1_r;
			sda_d_r <= sda_s2_r;
		end
	end

	// Edges only from the second stage onward
	always_comb begin
		scl_rise = scl_s2_r && !scl_d_r;
		scl_fall = !scl_s2_r && scl_d_r;
		start_det = scl_s2_r && scl_d_r && sda_d_r && !sda_s2_r;
		stop_det = scl_s2_r && scl_d_r && !sda_d_r && sda_s2_r;
	end

	// ----------------------------------------
	// Port state
	// ----------------------------------------
	i2cxm_pkg::i2cxm_state_t state_r, state_nxt;
	logic [7:0] shift_r, shift_nxt, buf_r, buf_nxt;
	logic [3:0] bitcnt_r, bitcnt_nxt, win_r, win_nxt;
	logic bf_r, bf_nxt, ov_r, ov_nxt, write_collision_flag_r, write_collision_flag_nxt, int_r, int_nxt;
	logic rw_r, rw_nxt, ckp_r, ckp_nxt, ackst_r, ackst_nxt, ackdrv_r, ackdrv_nxt;
	logic run_r, run_nxt, high_r, high_nxt;
	logic shifting, brg_en, brg_tick;

	// Baud rate generator, held at reload while a slave holds SCL low
	assign brg_en = run_r && (!high_r || scl_s2_r);

	i2cxm_baud u_baud (
		.clk_in(clk_in),
		.reset_n_in(reset_n_in),
		.enable_in(brg_en),
		.reload_in(baud_reload_in),
		.tick_out(brg_tick)
	);

	// Shifter busy, buffer writes collide
	assign shifting = (state_r == i2cxm_pkg::ST_STX && ckp_r) || (state_r == i2cxm_pkg::ST_MTX && run_r);

	// Next-state logic: clears first, hardware sets after so sets win
	always_comb begin
		state_nxt = state_r;
		shift_nxt = shift_r;
		buf_nxt = buf_r;
		bitcnt_nxt = bitcnt_r;
		bf_nxt = bf_r;
		ov_nxt = ov_r;
		write_collision_flag_nxt = write_collision_flag_r;
		int_nxt = int_r;
		rw_nxt = rw_r;
		ckp_nxt = ckp_r;
		ackst_nxt = ackst_r;
		ackdrv_nxt = ackdrv_r;
		run_nxt = run_r;
		high_nxt = high_r;
		win_nxt = (win_r != 4'h0) ? win_r - 4'h1 : 4'h0;
		if (int_clr_in) begin
			int_nxt = 1'b0;
		end
		if (write_collision_flag_clr_in) begin
			write_collision_flag_nxt = 1'b0;
		end
		if (ovf_clr_in) begin
			ov_nxt = 1'b0;
		end
		if (buf_rd_in && !master_mode_in) begin
			bf_nxt = 1'b0;
		end
		// Buffer write: load or collide
		if (buf_wr_in) begin
			if (shifting) begin
				write_collision_flag_nxt = 1'b1;
				win_nxt = WIN_CYC;
				if (win_r != 4'h0) begin
					buf_nxt = buf_wdata_in;
				end
			end else begin
				buf_nxt = buf_wdata_in;
				shift_nxt = buf_wdata_in;
				bf_nxt = 1'b1;
				if (master_mode_in) begin
					state_nxt = i2cxm_pkg::ST_MTX;
					run_nxt = 1'b1;
					high_nxt = 1'b0;
					bitcnt_nxt = 4'h0;
				end
			end
		end
		case (state_r)
			i2cxm_pkg::ST_SADDR: begin
				if (scl_rise) begin
					shift_nxt = {shift_r[6:0], sda_s2_r};
					bitcnt_nxt = bitcnt_r + 4'h1;
				end else if (scl_fall && bitcnt_r == LAST_BIT) begin
					if (!addr_match(shift_r, own_address_in)) begin
						state_nxt = i2cxm_pkg::ST_IDLE;
					end else if (!shift_r[`I2CXM_RW_BIT] && (bf_r || ov_r)) begin
						state_nxt = i2cxm_pkg::ST_IDLE;
					end else begin
						buf_nxt = shift_r;
						bf_nxt = !shift_r[`I2CXM_RW_BIT];
						rw_nxt = shift_r[`I2CXM_RW_BIT];
						ackdrv_nxt = 1'b1;
						state_nxt = i2cxm_pkg::ST_SACK;
					end
				end
			end
			i2cxm_pkg::ST_SACK: begin
				if (scl_fall) begin
					ackdrv_nxt = 1'b0;
					int_nxt = 1'b1;
					bitcnt_nxt = 4'h0;
					if (rw_r) begin
						ckp_nxt = 1'b0;
						state_nxt = i2cxm_pkg::ST_STX;
					end else begin
						state_nxt = i2cxm_pkg::ST_SRX;
						if (stretch_enable_in) begin
							ckp_nxt = 1'b0;
						end
					end
				end
			end
			i2cxm_pkg::ST_SRX: begin
				if (scl_rise) begin
					shift_nxt = {shift_r[6:0], sda_s2_r};
					bitcnt_nxt = bitcnt_r + 4'h1;
				end else if (scl_fall && bitcnt_r == LAST_BIT) begin
					if (bf_r || ov_r) begin
						ov_nxt = 1'b1;
					end else begin
						buf_nxt = shift_r;
						bf_nxt = 1'b1;
						ackdrv_nxt = 1'b1;
					end
					state_nxt = i2cxm_pkg::ST_SACK;
				end
			end
			i2cxm_pkg::ST_STX: begin
				if (scl_fall && ckp_r) begin
					shift_nxt = {shift_r[6:0], 1'b0};
					bitcnt_nxt = bitcnt_r + 4'h1;
					if (bitcnt_r == LAST_BIT - 4'h1) begin
						bf_nxt = 1'b0;
						state_nxt = i2cxm_pkg::ST_STXACK;
					end
				end
			end
			i2cxm_pkg::ST_STXACK: begin
				if (scl_rise && sda_s2_r) begin
					state_nxt = i2cxm_pkg::ST_IDLE;
					rw_nxt = 1'b0;
					bf_nxt = 1'b0;
				end else if (scl_fall) begin
					int_nxt = 1'b1;
					ckp_nxt = 1'b0;
					bitcnt_nxt = 4'h0;
					state_nxt = i2cxm_pkg::ST_STX;
				end
			end
			i2cxm_pkg::ST_MTX: begin
				if (brg_tick) begin
					if (!high_r) begin
						high_nxt = 1'b1;
					end else if (bitcnt_r == LAST_BIT) begin
						high_nxt = 1'b0;
						ackst_nxt = sda_s2_r;
						int_nxt = 1'b1;
						// Count stays on the ack bit so SDA floats while held
						run_nxt = 1'b0;
					end else begin
						high_nxt = 1'b0;
						shift_nxt = {shift_r[6:0], 1'b0};
						bitcnt_nxt = bitcnt_r + 4'h1;
						if (bitcnt_r == LAST_BIT - 4'h1) begin
							bf_nxt = 1'b0;
						end
					end
				end
			end
			default: begin
			end
		endcase
		if (!master_mode_in && start_det) begin
			state_nxt = i2cxm_pkg::ST_SADDR;
			bitcnt_nxt = 4'h0;
			ackdrv_nxt = 1'b0;
		end else if (!master_mode_in && stop_det) begin
			state_nxt = i2cxm_pkg::ST_IDLE;
			ackdrv_nxt = 1'b0;
		end
		if (clock_release_set_in) begin
			ckp_nxt = 1'b1;
		end
	end

	// State registers
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			state_r <= i2cxm_pkg::ST_IDLE;
			shift_r <= 8'h00;
			buf_r <= 8'h00;
			bitcnt_r <= 4'h0;
			win_r <= 4'h0;
			bf_r <= 1'b0;
			ov_r <= 1'b0;
			write_collision_flag_r <= 1'b0;
			int_r <= 1'b0;
			rw_r <= 1'b0;
			ckp_r <= 1'b1;
			ackst_r <= 1'b0;
			ackdrv_r <= 1'b0;
			run_r <= 1'b0;
			high_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			shift_r <= shift_nxt;
			buf_r <= buf_nxt;
			bitcnt_r <= bitcnt_nxt;
			win_r <= win_nxt;
			bf_r <= bf_nxt;
			ov_r <= ov_nxt;
			write_collision_flag_r <= write_collision_flag_nxt;
			int_r <= int_nxt;
			rw_r <= rw_nxt;
			ckp_r <= ckp_nxt;
			ackst_r <= ackst_nxt;
			ackdrv_r <= ackdrv_nxt;
			run_r <= run_nxt;
			high_r <= high_nxt;
		end
	end

	// ----------------------------------------
	// Pin drive and status outputs
	// ----------------------------------------
	always_comb begin
		scl_out = 1'b0;
		sda_out = 1'b0;
		scl_oe_out = (state_r == i2cxm_pkg::ST_MTX && !high_r) ||
			(!master_mode_in && !ckp_r && state_r != i2cxm_pkg::ST_IDLE);
		sda_oe_out = ackdrv_r ||
			(state_r == i2cxm_pkg::ST_STX && !shift_r[7]) ||
			(state_r == i2cxm_pkg::ST_MTX && bitcnt_r != LAST_BIT && !shift_r[7]);
	end

	assign serial_data_buffer_out = buf_r;
	assign buffer_full_flag_out = bf_r;
	assign receive_overflow_flag_out = ov_r;
	assign write_collision_flag_out = write_collision_flag_r;
	assign port_interrupt_flag_out = int_r;
	assign read_write_out = rw_r;
	assign acknowledge_status_bit_out = ackst_r;
	assign clock_release_bit_out = ckp_r;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (!reset_n_in);

	sequence s_addr_done;
		state_r == i2cxm_pkg::ST_SADDR && scl_fall && bitcnt_r == LAST_BIT && addr_match(shift_r, own_address_in)
			&& !start_det && !stop_det;
	endsequence
	sequence s_master_last_fall;
		state_r == i2cxm_pkg::ST_MTX && brg_tick && high_r && bitcnt_r == LAST_BIT;
	endsequence

	a_addr_ack_write: assert property (s_addr_done and (!shift_r[0] && !bf_r && !ov_r)
		|=> sda_oe_out && !rw_r && buf_r == $past(shift_r)) else $error("write address not acknowledged");
	a_addr_ovf_nack: assert property (s_addr_done and (!shift_r[0] && (bf_r || ov_r))
		|=> !sda_oe_out && state_r == i2cxm_pkg::ST_IDLE) else $error("address acked in overflow");
	a_rx_int_stretch: assert property (state_r == i2cxm_pkg::ST_SACK && scl_fall && !rw_r
		&& stretch_enable_in && !clock_release_set_in && !master_mode_in && !stop_det && !start_det
		|=> int_r && scl_oe_out) else $error("receive byte without flag or stretch");
	a_addr_read_ack: assert property (s_addr_done and shift_r[0]
		|=> sda_oe_out && rw_r && buf_r == $past(shift_r)) else $error("read address not acknowledged");
	a_addr_read_hold: assert property (state_r == i2cxm_pkg::ST_SACK && rw_r && scl_fall
		&& !clock_release_set_in && !master_mode_in && !stop_det && !start_det
		|=> scl_oe_out && !ckp_r) else $error("read address not stretched");
	a_tx_shift: assert property (state_r == i2cxm_pkg::ST_STX && ckp_r && scl_fall && bitcnt_r < 4'h7
		&& !start_det && !stop_det && !buf_wr_in |=> sda_oe_out == !$past(shift_r[6])) else $error("bad shift");
	a_tx_nack_end: assert property (state_r == i2cxm_pkg::ST_STXACK && scl_rise && sda_s2_r
		&& !master_mode_in |=> state_r == i2cxm_pkg::ST_IDLE && !rw_r && !bf_r) else $error("no reset after nack");
	a_master_start: assert property (master_mode_in && buf_wr_in && !shifting
		|=> bf_r && run_r && scl_oe_out [*2]) else $error("master write did not start");
	a_master_eighth: assert property (state_r == i2cxm_pkg::ST_MTX && brg_tick && high_r && bitcnt_r == 4'h7
		&& !buf_wr_in |=> !bf_r && !sda_oe_out) else $error("eighth fall did not release");
	a_master_ack: assert property (s_master_last_fall
		|=> ackst_r == $past(sda_s2_r) && int_r && !run_r ##1 scl_oe_out) else $error("ninth clock handling wrong");
	a_write_collision_flag_hold: assert property (buf_wr_in && shifting && win_r == 4'h0 && !write_collision_flag_clr_in
		|=> write_collision_flag_r && buf_r == $past(buf_r)) else $error("collision write changed buffer");

endmodule // i2cxm_top

/* tb/i2cxm_remote.sv */
// Purpose: Remote two-wire party, a master or a listening slave
// Assumes: Wires resolved by the bench with pull-ups
// Notes: Each SCL phase lasts at least HALF clock cycles
`timescale 1ns/100ps

module i2cxm_remote #(
	parameter int HALF = 20
) (
	input wire logic clk_in,
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic listen_in,
	input wire logic ack_en_in,
	output logic scl_oe_out,
	output logic sda_oe_out
);
	logic [7:0] got_r = 8'h00;
	int cnt = 0;

	// Both wires released at start
	initial begin
		scl_oe_out = 1'b0;
		sda_oe_out = 1'b0;
	end

	// ----------------------------------------
	// Remote master
	// ----------------------------------------
	task automatic half();
		repeat (HALF) @(posedge clk_in);
	endtask

	// Release SCL, wait out any stretch, sample SDA late in the high phase
	task automatic rise(output logic r);
		int n;
		n = 0;
		scl_oe_out <= 1'b0;
		@(posedge clk_in);
		while (scl_in !== 1'b1 && n < 5000) begin
			@(posedge clk_in);
			n++;
		end
		half();
		r = sda_in;
	endtask

	task automatic start();
		sda_oe_out <= 1'b1;
		half();
		scl_oe_out <= 1'b1;
		half();
	endtask

	// Nine bits: byte out (ones release SDA), then the ack bit
	task automatic xfer(input logic [7:0] d, input logic a, output logic [7:0] r, output logic ra);
		logic [8:0] o;
		logic [8:0] s;
		o = {d, a};
		for (int i = 8; i >= 0; i--) begin
			sda_oe_out <= ~o[i];
			half();
			rise(s[i]);
			scl_oe_out <= 1'b1;
			repeat (4) @(posedge clk_in);
		end
		r = s[8:1];
		ra = s[0];
	endtask

	task automatic stop();
		logic r;
		sda_oe_out <= 1'b1;
		half();
		rise(r);
		sda_oe_out <= 1'b0;
		half();
	endtask

	// ----------------------------------------
	// Listening slave
	// ----------------------------------------
	always @(posedge scl_in) begin
		if (listen_in) begin
			if (cnt < 8)
				got_r <= {got_r[6:0], sda_in};
			cnt <= (cnt == 8) ? 0 : cnt + 1;
		end
	end

	// Ack in the ninth bit, released with some hold time
	always @(negedge scl_in) begin
		if (listen_in)
			sda_oe_out <= #30 (cnt == 8) && ack_en_in;
	end
endmodule // i2cxm_remote

/* tb/test_i2cxm_top.sv */
// Purpose: Self-checking bench for the two-wire port
// Assumes: Pull-ups on both wires
// Notes: Slave rows in a table, then overflow, slave transmit, master
`timescale 1ns/100ps

module test_i2cxm_top;
	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] data;
		logic st;
		logic ack;
	} i2cxm_row_t;

	logic clk_in = 1'b0;
	logic reset_n_in = 1'b0;
	logic master_mode, stretch, buf_wr, buf_rd, rel_set, int_clr, write_collision_flag_clr, ovf_clr, listen, ack_en;
	logic [7:0] reload = 8'h09;
	logic [7:0] wdata = 8'h00;
	logic [7:0] rx, b, serial_data_buffer_out;
	logic ack, scl_oe_out, sda_oe_out, r_scl_oe, r_sda_oe, scl_w, sda_w;
	logic buffer_full_flag_out, receive_overflow_flag_out, write_collision_flag_out, port_interrupt_flag_out;
	logic read_write_out, acknowledge_status_bit_out, clock_release_bit_out;
	int num_errors = 0;
	int tests_run = 0;
	int cycles = 0;
	int n;
	i2cxm_row_t rows [3];

	// Open-drain wires with pull-ups
	assign scl_w = ~(scl_oe_out | r_scl_oe);
	assign sda_w = ~(sda_oe_out | r_sda_oe);

	always #5 clk_in = ~clk_in;

	i2cxm_top i2cxm_top_i (.clk_in, .reset_n_in, .scl_in(scl_w), .scl_out(), .scl_oe_out, .sda_in(sda_w),
		.sda_out(), .sda_oe_out, .master_mode_in(master_mode), .stretch_enable_in(stretch),
		.own_address_in(7'h2D), .baud_reload_in(reload), .buf_wr_in(buf_wr), .buf_wdata_in(wdata),
		.buf_rd_in(buf_rd), .clock_release_set_in(rel_set), .int_clr_in(int_clr), .write_collision_flag_clr_in(write_collision_flag_clr),
		.ovf_clr_in(ovf_clr), .serial_data_buffer_out, .buffer_full_flag_out, .receive_overflow_flag_out,
		.write_collision_flag_out, .port_interrupt_flag_out, .read_write_out, .acknowledge_status_bit_out,
		.clock_release_bit_out);

	i2cxm_remote i2cxm_remote_i (.clk_in, .scl_in(scl_w), .sda_in(sda_w), .listen_in(listen),
		.ack_en_in(ack_en), .scl_oe_out(r_scl_oe), .sda_oe_out(r_sda_oe));

	// ----------------------------------------
	// Compare, strobe and software tasks
	// ----------------------------------------
	task automatic chk1(input logic g, input logic e, input string m);
		tests_run++;
		if (g !== e) begin
			num_errors++;
			$display("CHECK FAILED %0t %s got %b exp %b", $time, m, g, e);
		end
	endtask

	task automatic chk8(input logic [7:0] g, input logic [7:0] e, input string m);
		tests_run++;
		if (g !== e) begin
			num_errors++;
			$display("CHECK FAILED %0t %s got %h exp %h", $time, m, g, e);
		end
	endtask

	task automatic pulse(ref logic s);
		@(posedge clk_in);
		#1 s = 1'b1;
		@(posedge clk_in);
		#1 s = 1'b0;
	endtask

	task automatic wait_int();
		int k;
		k = 0;
		while (port_interrupt_flag_out !== 1'b1 && k < 4000) begin
			@(posedge clk_in);
			#1 k++;
		end
		chk1(port_interrupt_flag_out, 1'b1, "irq");
	endtask

	// Slave receive service: clear flag, read buffer, release clock
	task automatic serve(output logic [7:0] d);
		wait_int();
		chk1(scl_oe_out, stretch, "stretch hold");
		d = serial_data_buffer_out;
		pulse(int_clr);
		pulse(buf_rd);
		pulse(rel_set);
	endtask

	// Slave transmit service: load next byte, release clock
	task automatic prep(input logic [7:0] d);
		wait_int();
		chk1(scl_oe_out, 1'b1, "tx hold");
		chk1(clock_release_bit_out, 1'b0, "release low");
		pulse(int_clr);
		wdata = d;
		pulse(buf_wr);
		pulse(rel_set);
	endtask

	task automatic wait_oe(input logic v);
		n = 0;
		while (scl_oe_out !== v && n < 500) begin
			@(posedge clk_in);
			#1 n++;
		end
	endtask

	// Length of the next full SCL low phase in clock cycles
	task automatic low_len(output int c);
		wait_oe(1'b0);
		wait_oe(1'b1);
		c = 0;
		while (scl_oe_out === 1'b1 && c < 500) begin
			@(posedge clk_in);
			#1 c++;
		end
	endtask

	task automatic finish_test();
		$display("checks %0d errors %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// Hang guard
	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 20000) begin
			num_errors++;
			finish_test();
		end
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		{master_mode, stretch, buf_wr, buf_rd, rel_set, int_clr, write_collision_flag_clr, ovf_clr, listen, ack_en} = '0;
		rows[0] = {8'h5A, 8'hA5, 1'b1, 1'b1};
		rows[1] = {8'h5A, 8'h3C, 1'b0, 1'b1};
		rows[2] = {8'h5C, 8'h00, 1'b0, 1'b0};
		repeat (3) @(posedge clk_in);
		#1 reset_n_in = 1'b1;
		repeat (3) @(posedge clk_in);
		chk8(serial_data_buffer_out, 8'h00, "reset buf");
		chk1(clock_release_bit_out, 1'b1, "reset release");
		chk1(buffer_full_flag_out | port_interrupt_flag_out | scl_oe_out | sda_oe_out, 1'b0, "reset idle");
		$display("test reset done");
		for (int i = 0; i < 3; i++) begin
			stretch = rows[i].st;
			i2cxm_remote_i.start();
			fork
				i2cxm_remote_i.xfer(rows[i].addr, 1'b1, rx, ack);
				if (rows[i].ack) serve(b);
			join
			chk1(ack, ~rows[i].ack, "addr ack");
			if (rows[i].ack) begin
				chk8(b, rows[i].addr, "addr buf");
				chk1(read_write_out, 1'b0, "rw clear");
				fork
					i2cxm_remote_i.xfer(rows[i].data, 1'b1, rx, ack);
					serve(b);
				join
				chk1(ack, 1'b0, "data ack");
				chk8(b, rows[i].data, "data buf");
			end
			i2cxm_remote_i.stop();
			$display("test row %0d done", i);
		end
		stretch = 1'b0;
		i2cxm_remote_i.start();
		i2cxm_remote_i.xfer(8'h5A, 1'b1, rx, ack);
		chk1(buffer_full_flag_out, 1'b1, "full");
		pulse(int_clr);
		i2cxm_remote_i.xfer(8'h77, 1'b1, rx, ack);
		chk1(receive_overflow_flag_out, 1'b1, "ovf set");
		chk1(port_interrupt_flag_out, 1'b1, "ovf irq");
		i2cxm_remote_i.stop();
		i2cxm_remote_i.start();
		i2cxm_remote_i.xfer(8'h5A, 1'b1, rx, ack);
		chk1(ack, 1'b1, "addr nack");
		i2cxm_remote_i.stop();
		pulse(ovf_clr);
		pulse(buf_rd);
		pulse(int_clr);
		$display("test overflow done");
		i2cxm_remote_i.start();
		fork
			i2cxm_remote_i.xfer(8'h5B, 1'b1, rx, ack);
			prep(8'h96);
		join
		chk1(ack, 1'b0, "read addr ack");
		chk1(read_write_out, 1'b1, "rw set");
		fork
			i2cxm_remote_i.xfer(8'hFF, 1'b0, rx, ack);
			prep(8'h5A);
		join
		chk8(rx, 8'h96, "tx byte");
		i2cxm_remote_i.xfer(8'hFF, 1'b1, rx, ack);
		chk8(rx, 8'h5A, "tx byte two");
		chk1(read_write_out | buffer_full_flag_out | scl_oe_out, 1'b0, "nack idle");
		i2cxm_remote_i.stop();
		pulse(int_clr);
		$display("test slave transmit done");
		master_mode = 1'b1;
		listen = 1'b1;
		ack_en = 1'b1;
		wdata = 8'hA4;
		pulse(buf_wr);
		chk1(buffer_full_flag_out, 1'b1, "mtx full");
		low_len(n);
		chk8(8'(n), reload + 8'h01, "low phase");
		wdata = 8'h11;
		pulse(buf_wr);
		chk1(write_collision_flag_out, 1'b1, "write_collision_flag");
		repeat (10) @(posedge clk_in);
		chk8(serial_data_buffer_out, 8'hA4, "buf kept");
		wdata = 8'h22;
		pulse(buf_wr);
		wdata = 8'h33;
		pulse(buf_wr);
		chk8(serial_data_buffer_out, 8'h33, "rewrite");
		pulse(write_collision_flag_clr);
		chk1(write_collision_flag_out, 1'b0, "write_collision_flag clr");
		wait_int();
		chk8(i2cxm_remote_i.got_r, 8'hA4, "addr bits");
		chk1(acknowledge_status_bit_out, 1'b0, "ack stat");
		chk1(buffer_full_flag_out, 1'b0, "full clr");
		repeat (40) @(posedge clk_in);
		chk1(scl_oe_out, 1'b1, "scl held");
		chk1(sda_oe_out, 1'b0, "sda free");
		ack_en = 1'b0;
		reload = 8'h04;
		pulse(int_clr);
		wdata = 8'h3C;
		pulse(buf_wr);
		low_len(n);
		chk8(8'(n), 8'h05, "low phase short");
		wait_int();
		chk8(i2cxm_remote_i.got_r, 8'h3C, "data bits");
		chk1(acknowledge_status_bit_out, 1'b1, "nack stat");
		$display("test master done");
		finish_test();
	end
endmodule // test_i2cxm_top
